/* File: logic/fpe_defs.vh */
`ifndef FPE_DEFS_VH
`define FPE_DEFS_VH

// Array geometry: byte address, top bit selects the bank
`define FPE_ADDR_W        10
`define FPE_BANK_BIT      9
`define FPE_SECT_W        3
`define FPE_SECT_BYTES_W  7
`define FPE_SECT_LAST     7'h7F

// Program unit sizes, in bytes, minus one
`define FPE_PWL_LAST      7'h3F
`define FPE_DWL_LAST      7'h1F
`define FPE_PWL_MASK      10'h3C0
`define FPE_DWL_MASK      10'h3E0

// Stored word: eight data bits and four check bits
`define FPE_DATA_W        8
`define FPE_CHK_W         4
`define FPE_WORD_W        12

// Operation lengths in system clock cycles
`define FPE_PROG_CYCLES   248256
`define FPE_ERASE_CYCLES  9807360
`define FPE_CNT_W         24

`endif

/* File: logic/fpe_mem.v */
`timescale 1ns/10ps
// Simple two-port memory: one write port, one registered read port
module fpe_mem #(
  parameter AW = 10,
  parameter DW = 12
) (
  clk,
  we,
  waddr,
  wdata,
  raddr,
  rdata
);
  input  wire          clk;    // System clock
  input  wire          we;     // Write strobe
  input  wire [AW-1:0] waddr;  // Write address
  input  wire [DW-1:0] wdata;  // Write data
  input  wire [AW-1:0] raddr;  // Read address
  output reg  [DW-1:0] rdata;  // Read data, one cycle after the address

  reg [DW-1:0] mem_reg [0:(1<<AW)-1];  // Storage cells
  integer i;

  // Shipped erased: every cell reads as zero
  initial begin
    for (i = 0; i < (1<<AW); i = i + 1) begin
      mem_reg[i] = {DW{1'b0}};
    end
  end

  // Write port and registered read port
  always @(posedge clk) begin
    if (we) begin
      mem_reg[waddr] <= wdata;
    end
    rdata <= mem_reg[raddr];
  end
endmodule

/* File: logic/fpe_ctrl.v */
`timescale 1ns/10ps
`include "fpe_defs.vh"

// Functional notes
// RQ1 - Program 32-byte data, 64-byte program wordlines
// RQ2 - Erase granularity is one sector
// RQ3 - Erase touches only the chosen sector
// RQ4 - Erased and shipped cells read zero
// RQ5 - Requester programs program wordlines once only
// RQ6 - Requester programs data wordlines twice max
// RQ7 - Byte read completes within three cycles
// RQ8 - Program takes 248256 system clocks
// RQ9 - Erase takes 9807360 system clocks
// RQ10 - Requester programs only near 96 MHz; the bench requester programs on a 40 MHz clock
// RQ11 - Program and erase run in background
// RQ12 - Abort stops erase, returns to idle
// RQ13 - Reads correct single-bit errors
// RQ14 - Busy held; new operations refused meanwhile
// RQ15 - Completion event on finish or abort
module fpe_ctrl #(
  parameter PROG_CYCLES  = `FPE_PROG_CYCLES,
  parameter ERASE_CYCLES = `FPE_ERASE_CYCLES
) (
  clk,
  reset_n,
  rd_req,
  rd_addr,
  ld_req,
  ld_offset,
  ld_data,
  prog_req,
  prog_addr,
  erase_req,
  erase_sector,
  abort_req,
  rd_valid,
  rd_data,
  rd_corrected,
  busy,
  done,
  aborted,
  refused
);
  input  wire                    clk;           // System clock
  input  wire                    reset_n;       // Synchronous reset, active low
  input  wire                    rd_req;        // Byte read request
  input  wire [`FPE_ADDR_W-1:0]  rd_addr;       // Byte read address
  input  wire                    ld_req;        // Load one byte into page buffer
  input  wire [5:0]              ld_offset;     // Page buffer byte offset
  input  wire [`FPE_DATA_W-1:0]  ld_data;       // Page buffer byte
  input  wire                    prog_req;      // Start wordline program
  input  wire [`FPE_ADDR_W-1:0]  prog_addr;     // Any address in the wordline
  input  wire                    erase_req;     // Start sector erase
  input  wire [`FPE_SECT_W-1:0]  erase_sector;  // Sector number
  input  wire                    abort_req;     // Abort a running erase
  output reg                     rd_valid;      // Read data valid pulse
  output reg  [`FPE_DATA_W-1:0]  rd_data;       // Corrected read byte
  output reg                     rd_corrected;  // A bit was repaired
  output reg                     busy;          // Program or erase running
  output reg                     done;          // Operation finished pulse
  output reg                     aborted;       // Finish was by abort
  output reg                     refused;       // Request turned away pulse

  // Operation states
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_PROG  = 2'b01;
  localparam [1:0] ST_ERASE = 2'b10;

  // Last cycle counts of each operation
  localparam [`FPE_CNT_W-1:0] PROG_LAST  = PROG_CYCLES[`FPE_CNT_W-1:0] - 1'b1;
  localparam [`FPE_CNT_W-1:0] ERASE_LAST = ERASE_CYCLES[`FPE_CNT_W-1:0] - 1'b1;

  // Check bits over one byte, Hamming positions 1, 2, 4, 8
  function [`FPE_CHK_W-1:0] fpe_chk;
    input [7:0] d;
    begin
      fpe_chk[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
      fpe_chk[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
      fpe_chk[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
      fpe_chk[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
    end
  endfunction

  // Flip the data bit that a syndrome points at
  function [7:0] fpe_fix;
    input [7:0] d;
    input [3:0] syn;
    begin
      fpe_fix = d;
      case (syn)
        4'h3: fpe_fix[0] = ~d[0];
        4'h5: fpe_fix[1] = ~d[1];
        4'h6: fpe_fix[2] = ~d[2];
        4'h7: fpe_fix[3] = ~d[3];
        4'h9: fpe_fix[4] = ~d[4];
        4'hA: fpe_fix[5] = ~d[5];
        4'hB: fpe_fix[6] = ~d[6];
        4'hC: fpe_fix[7] = ~d[7];
        default: fpe_fix = d;
      endcase
    end
  endfunction

  reg  [1:0]                 state_reg;     // Operation state
  reg  [1:0]                 state_next;
  reg  [`FPE_CNT_W-1:0]      cnt_reg;       // Cycles spent in operation
  reg  [`FPE_ADDR_W-1:0]     base_reg;      // Wordline or sector base
  reg  [6:0]                 last_reg;      // Last byte index of copy/clear
  reg  [7:0]                 idx_reg;       // Byte index issued to buffer/array
  reg                        wr_pend_reg;   // Buffer byte ready to write
  reg  [6:0]                 wr_idx_reg;    // Index of that byte
  reg                        rd_pend_reg;   // Array read in flight
  wire                       start_ok;      // Idle and free to start
  wire                       copying;       // Byte index still inside unit
  wire [`FPE_WORD_W-1:0]     arr_rdata;     // Raw stored word
  wire [`FPE_DATA_W-1:0]     pb_rdata;      // Page buffer byte
  reg                        arr_we;        // Array write strobe
  reg  [`FPE_ADDR_W-1:0]     arr_waddr;     // Array write address
  reg  [`FPE_WORD_W-1:0]     arr_wdata;     // Array write word
  wire [3:0]                 syn;           // Read syndrome

  assign start_ok = (state_reg == ST_IDLE);
  assign copying  = (idx_reg <= {1'b0, last_reg});
  assign syn      = arr_rdata[11:8] ^ fpe_chk(arr_rdata[7:0]);

  // Flash array: bank 0 program bank, bank 1 data bank
  fpe_mem #(
    .AW (`FPE_ADDR_W),
    .DW (`FPE_WORD_W)
  ) u_array (
    .clk   (clk),
    .we    (arr_we),
    .waddr (arr_waddr),
    .wdata (arr_wdata),
    .raddr (rd_addr),
    .rdata (arr_rdata)
  );

  // Page buffer; loads are only taken while idle so a program sees stable data
  fpe_mem #(
    .AW (6),
    .DW (`FPE_DATA_W)
  ) u_page (
    .clk   (clk),
    .we    (ld_req & start_ok),
    .waddr (ld_offset),
    .wdata (ld_data),
    .raddr (idx_reg[5:0]),
    .rdata (pb_rdata)
  );

  // Array write source: program copy or erase clear
  always @* begin
    arr_we    = 1'b0;
    arr_waddr = base_reg;
    arr_wdata = {`FPE_WORD_W{1'b0}};
    if (state_reg == ST_PROG && wr_pend_reg) begin
      arr_we    = 1'b1;
      arr_waddr = base_reg | {3'h0, wr_idx_reg};
      arr_wdata = {fpe_chk(pb_rdata), pb_rdata}; // RQ1
    end else if (state_reg == ST_ERASE && copying) begin
      // Zero data has zero check bits, so cleared cells read zero cleanly
      arr_we    = 1'b1;
      arr_waddr = base_reg | {3'h0, idx_reg[6:0]}; // RQ3
      arr_wdata = {`FPE_WORD_W{1'b0}}; // RQ4
    end
  end

  // Next state of the operation sequencer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (prog_req) begin
          state_next = ST_PROG;
        end else if (erase_req) begin
          state_next = ST_ERASE;
        end
      end
      ST_PROG: begin
        if (cnt_reg == PROG_LAST) begin
          state_next = ST_IDLE; // RQ8
        end
      end
      ST_ERASE: begin
        if (abort_req || cnt_reg == ERASE_LAST) begin
          state_next = ST_IDLE; // RQ9 RQ12
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Sequencer registers, counter and status outputs
  always @(posedge clk) begin
    if (!reset_n) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= {`FPE_CNT_W{1'b0}};
      base_reg    <= {`FPE_ADDR_W{1'b0}};
      last_reg    <= 7'h00;
      idx_reg     <= 8'hFF;
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 7'h00;
      busy        <= 1'b0;
      done        <= 1'b0;
      aborted     <= 1'b0;
      refused     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      done        <= 1'b0;
      refused     <= 1'b0;
      wr_pend_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= {`FPE_CNT_W{1'b0}};
          idx_reg <= 8'h00;
          if (prog_req) begin
            // Unit size follows the bank; low address bits are ignored
            if (prog_addr[`FPE_BANK_BIT]) begin
              base_reg <= prog_addr & `FPE_DWL_MASK; // RQ1
              last_reg <= `FPE_DWL_LAST;
            end else begin
              base_reg <= prog_addr & `FPE_PWL_MASK; // RQ1
              last_reg <= `FPE_PWL_LAST;
            end
            busy    <= 1'b1; // RQ14
            aborted <= 1'b0;
          end else if (erase_req) begin
            base_reg <= {erase_sector, 7'h00}; // RQ2
            last_reg <= `FPE_SECT_LAST;
            busy     <= 1'b1; // RQ14
            aborted  <= 1'b0;
          end
        end
        default: begin
          // A program or erase request while busy is dropped and flagged
          if (prog_req || erase_req) begin
            refused <= 1'b1; // RQ14
          end
          cnt_reg <= cnt_reg + 1'b1;
          if (copying) begin
            idx_reg <= idx_reg + 1'b1;
          end
          // Buffer read is registered, so the write trails the index by one
          wr_pend_reg <= copying;
          wr_idx_reg  <= idx_reg[6:0];
          if (state_next == ST_IDLE) begin
            busy    <= 1'b0; // RQ14
            done    <= 1'b1; // RQ15
            aborted <= (state_reg == ST_ERASE) && abort_req; // RQ12
          end
        end
      endcase
    end
  end

  // Read path stays live during program and erase, so the core never stalls
  always @(posedge clk) begin
    if (!reset_n) begin
      rd_pend_reg  <= 1'b0;
      rd_valid     <= 1'b0;
      rd_data      <= 8'h00;
      rd_corrected <= 1'b0;
    end else begin
      rd_pend_reg <= rd_req; // RQ11
      rd_valid    <= rd_pend_reg; // RQ7
      if (rd_pend_reg) begin
        rd_data      <= fpe_fix(arr_rdata[7:0], syn); // RQ13
        rd_corrected <= (syn != 4'h0);
      end
    end
  end
endmodule

/* File: verif/fpe_ctrl_checker.sv */
`timescale 1ns/10ps
`include "fpe_defs.vh"
// Port checker; the kind of the running op and its busy length sit in helper registers
module fpe_ctrl_checker #(
  parameter PROG_CYCLES  = `FPE_PROG_CYCLES,
  parameter ERASE_CYCLES = `FPE_ERASE_CYCLES
) (
  input wire clk,
  input wire reset_n,
  input wire rd_req,
  input wire prog_req,
  input wire erase_req,
  input wire abort_req,
  input wire rd_valid,
  input wire busy,
  input wire done,
  input wire aborted,
  input wire refused
);
  reg        erase_reg;  // Running op is an erase
  reg [23:0] cnt_reg;    // Busy cycles seen so far
  wire       start = (prog_req || erase_req) && !busy;  // Accepted start
  // Latch op kind at each start; count busy cycles, cleared when idle
  always @(posedge clk) begin
    if (!reset_n) begin
      erase_reg <= 1'b0;
      cnt_reg   <= 24'h000000;
    end else begin
      if (start) erase_reg <= !prog_req;
      cnt_reg <= busy ? cnt_reg + 24'h000001 : 24'h000000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_start;
    start;
  endsequence
  sequence s_clash;
    (prog_req || erase_req) && busy;
  endsequence
  sequence s_abort;
    busy && erase_reg && abort_req;
  endsequence
  chk_read_answer: assert property (rd_req |-> ##2 rd_valid)
    else $error("read answer missing two cycles after request");
  chk_valid_cause: assert property (rd_valid |-> $past(rd_req, 2))
    else $error("read answer without request");
  chk_start_busy: assert property (s_start |=> busy && !done)
    else $error("busy not raised after start");
  chk_clash_refused: assert property (s_clash |=> refused)
    else $error("request during busy not refused");
  chk_refused_cause: assert property (refused |-> $past(busy) &&
    ($past(prog_req) || $past(erase_req)))
    else $error("refusal without a clashing request");
  chk_done_end: assert property (done |-> !busy && $past(busy))
    else $error("finish pulse not at end of busy");
  chk_abort_stop: assert property (s_abort |=> done && aborted && !busy)
    else $error("abort did not stop the erase");
  chk_run_length: assert property (done && !aborted |->
    cnt_reg == (erase_reg ? ERASE_CYCLES : PROG_CYCLES))
    else $error("operation length wrong");
  chk_no_early: assert property (busy |->
    cnt_reg < (erase_reg ? ERASE_CYCLES : PROG_CYCLES))
    else $error("busy longer than operation length");
endmodule
bind fpe_ctrl fpe_ctrl_checker #(
  .PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)
) i_fpe_ctrl_checker (
  .clk(clk), .reset_n(reset_n), .rd_req(rd_req), .prog_req(prog_req), .erase_req(erase_req),
  .abort_req(abort_req), .rd_valid(rd_valid), .busy(busy), .done(done), .aborted(aborted),
  .refused(refused)
);

/* File: verif/fpe_cpu.sv */
`timescale 1ns/10ps
// Requester model: one request per call, raised and dropped on falling edges
module fpe_cpu (
  input  wire       clk,
  output reg        rd_req,
  output reg  [9:0] rd_addr,
  output reg        ld_req,
  output reg  [5:0] ld_offset,
  output reg  [7:0] ld_data,
  output reg        prog_req,
  output reg  [9:0] prog_addr,
  output reg        erase_req,
  output reg  [2:0] erase_sector,
  output reg        abort_req
);
  // Idle at time zero
  initial begin
    {abort_req, erase_req, prog_req, ld_req, rd_req} = 5'h00;
    {rd_addr, prog_addr, erase_sector, ld_offset, ld_data} = 37'h0;
  end
  // Strobe kinds k = {abort, erase, prog, load, read}; only from the system clock
  task send(input [4:0] k, input [9:0] a, input [7:0] d);
    begin
      @(negedge clk);
      {abort_req, erase_req, prog_req, ld_req, rd_req} = k;
      {rd_addr, prog_addr, erase_sector, ld_offset, ld_data} = {a, a, a[9:7], a[5:0], d};
      @(negedge clk);
      {abort_req, erase_req, prog_req, ld_req, rd_req} = 5'h00;
      // Released lines do not keep the last value
      {rd_addr, prog_addr, erase_sector, ld_offset, ld_data} = ~{a, a, a[9:7], a[5:0], d};
    end
  endtask
endmodule

/* File: verif/fpe_ctrl_tb.sv */
`timescale 1ns/10ps
// Self-checking bench for the flash sequencer
module fpe_ctrl_tb;
  localparam int       PC = 200;  // Shortened program length
  localparam int       EC = 300;  // Shortened erase length
  localparam     [4:0] K_RD = 5'h01, K_LD = 5'h02, K_PR = 5'h04, K_ER = 5'h08, K_AB = 5'h10;
  reg        clk;
  reg        reset_n;
  wire       rd_req, ld_req, prog_req, erase_req, abort_req;
  wire       rd_valid, rd_corrected, busy, done, aborted, refused;
  wire [9:0] rd_addr, prog_addr;
  wire [7:0] ld_data, rd_data;
  wire [5:0] ld_offset;
  wire [2:0] erase_sector;
  int        n_errors = 0;
  int        total_checks = 0;
  fpe_ctrl #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) i_fpe_ctrl (
    .clk(clk), .reset_n(reset_n), .rd_req(rd_req), .rd_addr(rd_addr), .ld_req(ld_req),
    .ld_offset(ld_offset), .ld_data(ld_data), .prog_req(prog_req), .prog_addr(prog_addr),
    .erase_req(erase_req), .erase_sector(erase_sector), .abort_req(abort_req),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_corrected(rd_corrected), .busy(busy),
    .done(done), .aborted(aborted), .refused(refused));
  fpe_cpu i_fpe_cpu (
    .clk(clk), .rd_req(rd_req), .rd_addr(rd_addr), .ld_req(ld_req), .ld_offset(ld_offset),
    .ld_data(ld_data), .prog_req(prog_req), .prog_addr(prog_addr), .erase_req(erase_req),
    .erase_sector(erase_sector), .abort_req(abort_req));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks++;
      if (got !== exp) begin
        n_errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  // Read one byte; the answer stands one cycle after the call returns
  task rd_chk(input [9:0] a, input [7:0] e);
    begin
      i_fpe_cpu.send(K_RD, a, 8'h00);
      @(negedge clk);
      chk(rd_valid, 1'b1);
      chk(rd_data, e);
      chk(rd_corrected, 1'b0);
    end
  endtask
  // Count falling edges to the finish pulse, bounded so a hang cannot stall
  task wait_done(output int k);
    begin
      k = 0;
      while (done !== 1'b1 && k < 20000) begin
        @(negedge clk);
        k++;
      end
    end
  endtask
  // Fill all 64 buffer bytes, program one wordline, check its extent exactly
  task t_prog(input [9:0] a, input [9:0] base, input int n, input [7:0] s);
    int k;
    begin
      for (int i = 0; i < 64; i++) i_fpe_cpu.send(K_LD, i[9:0], s ^ i[7:0]);
      i_fpe_cpu.send(K_PR, a, 8'h00);
      chk(busy, 1'b1);
      wait_done(k);
      chk(k, PC);
      chk(aborted, 1'b0);
      for (int i = 0; i < n; i++) rd_chk(base + i[9:0], s ^ i[7:0]);
      rd_chk(base + n[9:0], 8'h00);
      rd_chk(base - 10'h001, 8'h00);
    end
  endtask
  // Erase sector 4; its data goes, program sector 0 keeps its data
  task t_erase;
    int k;
    begin
      i_fpe_cpu.send(K_ER, 10'h200, 8'h00);
      wait_done(k);
      chk(k, EC);
      rd_chk(10'h260, 8'h00);
      rd_chk(10'h27F, 8'h00);
      rd_chk(10'h040, 8'hC3);
    end
  endtask
  // Clash a program into a running erase, read meanwhile, then abort
  task t_abort;
    begin
      i_fpe_cpu.send(K_ER, 10'h000, 8'h00);
      i_fpe_cpu.send(K_PR, 10'h200, 8'h00);
      chk(refused, 1'b1);
      rd_chk(10'h3FF, 8'h00);
      i_fpe_cpu.send(K_AB, 10'h000, 8'h00);
      chk(done, 1'b1);
      chk(aborted, 1'b1);
      chk(busy, 1'b0);
      @(negedge clk);
      chk(done, 1'b0);
    end
  endtask
  // Plant single-bit faults straight in the array, then read them back repaired
  task t_ecc;
    begin
      @(negedge clk);
      i_fpe_ctrl.u_array.mem_reg[10'h300] = 12'h0DA;  // 5A with its top data bit flipped
      i_fpe_ctrl.u_array.mem_reg[10'h301] = 12'h100;  // Zero with one check bit flipped
      i_fpe_cpu.send(K_RD, 10'h300, 8'h00);
      @(negedge clk);
      chk(rd_valid, 1'b1);
      chk(rd_data, 8'h5A);
      chk(rd_corrected, 1'b1);
      i_fpe_cpu.send(K_RD, 10'h301, 8'h00);
      @(negedge clk);
      chk(rd_data, 8'h00);
      chk(rd_corrected, 1'b1);
    end
  endtask
  // System clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Main sequence; each wordline is programmed once only
  initial begin
    reset_n = 1'b0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    rd_chk(10'h000, 8'h00);
    rd_chk(10'h3FF, 8'h00);
    t_prog(10'h265, 10'h260, 32, 8'h3C);
    t_prog(10'h045, 10'h040, 64, 8'hC3);
    t_erase;
    t_abort;
    t_ecc;
    results;
  end
  // Watchdog, well above the expected run of about 1300 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    results;
  end
endmodule
